// ### hdl/ctrc_defs.vh
// Constants for the calibration and trim control register bank.
`ifndef CTRC_DEFS_VH
`define CTRC_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define CTRC_ADDR_W 5
`define CTRC_DATA_W 8
`define CTRC_ADDR_CAL 5'h10
`define CTRC_ADDR_TRIM_SRC 5'h11
`define CTRC_ADDR_SHADOW_FIRST 5'h12
`define CTRC_ADDR_SHADOW_LAST 5'h16
`define CTRC_SHADOW_COUNT 5

// ****************************************
// Reset values and write masks
// ****************************************
`define CTRC_CAL_RESET 8'h00
`define CTRC_TRIM_SRC_RESET 8'h00
`define CTRC_SHADOW_RESET 8'h00
`define CTRC_CAL_MASK 8'h9a
`define CTRC_TRIM_SRC_MASK 8'h03

// ****************************************
// Field positions
// ****************************************
`define CTRC_CAL_SHORT_BIT 7
`define CTRC_CAL_POS_CONT_BIT 4
`define CTRC_CAL_NEG_CONT_BIT 3
`define CTRC_CAL_GROUND_BIT 1
`define CTRC_TRIM_OUT_SEL_BIT 1
`define CTRC_TRIM_LOAD_BIT 0
`define CTRC_REF_ADJ_INDEX 0
`define CTRC_REF_ADJ_W 5
`define CTRC_OFFSET_INDEX 1
`define CTRC_OFFSET_W 4
`define CTRC_MONITOR_INDEX 4
`define CTRC_MON_POS_BIT 0
`define CTRC_MON_NEG_BIT 1
`define CTRC_MON_FIVE_BIT 2
`define CTRC_MON_REF_BIT 3

`endif

// ### hdl/ctrc_regs.v
// Calibration, continuity test and trim source control register bank.

`default_nettype none
`include "ctrc_defs.vh"

module ctrc_regs #(
    parameter SHADOW_COUNT = `CTRC_SHADOW_COUNT
) (
    input wire clock,
    input wire resetn,
    input wire [`CTRC_ADDR_W-1:0] reg_addr,
    input wire [`CTRC_DATA_W-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [`CTRC_DATA_W-1:0] reg_rdata,
    output reg reg_rvalid,
    input wire [SHADOW_COUNT*`CTRC_DATA_W-1:0] fused_trim,
    output reg [SHADOW_COUNT*`CTRC_DATA_W-1:0] trim_out,
    output reg channel_select_override,
    output reg amp_input_short,
    output reg amp_inv_to_ground,
    output reg pos_continuity_check,
    output reg neg_continuity_check,
    output reg noninv_to_ref_div,
    output reg [`CTRC_REF_ADJ_W-1:0] reference_adjust,
    output reg [`CTRC_OFFSET_W-1:0] offset_adjust,
    output reg offset_cal_active,
    output reg monitor_pos_rail,
    output reg monitor_neg_rail,
    output reg monitor_five_volt,
    output reg monitor_reference
);

    localparam DW = `CTRC_DATA_W;

    // ****************************************
    // Register map
    // ****************************************

    // Address 0x10 holds the calibration switches. Bit 7 shorts the amplifier
    // inputs together and bit 1 grounds the inverting input; either one takes
    // the input switches away from the channel select setting.
    // Bit 4 sends the test current into the non-inverting path, and bit 3
    // sends it into the inverting path while the non-inverting input sits on
    // the divided reference. Bits 6, 5, 2 and 0 are not implemented.
    //
    // Address 0x11 selects the trim source. Bit 1 chooses the shadow registers
    // over the fuses for the trim outputs, and bit 0 loads the fused values
    // into the shadows. Bits 7 to 2 are not implemented.
    //
    // Addresses 0x12 to 0x16 are the five shadow trim bytes, one per fused
    // byte. The byte at 0x12 carries the reference adjust in bits 4 to 0, the
    // byte at 0x13 the amplifier offset in bits 3 to 0, and the byte at 0x16
    // the four supply monitor selects in bits 3 to 0.
    //
    // Reads of any other address return zero and writes to them are dropped.
    // Setting the load bit and the out-select bit together makes the outputs
    // follow the fuses through the shadows, which lets the host check the
    // load path before it starts to edit the shadows.

    // ****************************************
    // Address decode
    // ****************************************

    // Returns the shadow index for an address, or SHADOW_COUNT when none.
    function integer shadow_index;
        input [`CTRC_ADDR_W-1:0] addr;
        begin
            if (addr >= `CTRC_ADDR_SHADOW_FIRST && addr <= `CTRC_ADDR_SHADOW_LAST) begin
                shadow_index = addr - `CTRC_ADDR_SHADOW_FIRST;
            end else begin
                shadow_index = SHADOW_COUNT;
            end
        end
    endfunction

    // Keeps only the implemented positions of a control register.
    function [DW-1:0] keep_bits;
        input [DW-1:0] value;
        input [DW-1:0] mask;
        begin
            keep_bits = value & mask;
        end
    endfunction

    // ****************************************
    // Stored state
    // ****************************************

    reg [DW-1:0] cal_ctrl;
    reg [DW-1:0] trim_src_ctrl;
    reg [DW-1:0] shadow [0:SHADOW_COUNT-1];

    wire cal_write;
    wire trim_src_write;
    wire trim_load;
    wire trim_out_sel;

    assign cal_write = reg_write && (reg_addr == `CTRC_ADDR_CAL);
    assign trim_src_write = reg_write && (reg_addr == `CTRC_ADDR_TRIM_SRC);
    assign trim_load = trim_src_ctrl[`CTRC_TRIM_LOAD_BIT];
    assign trim_out_sel = trim_src_ctrl[`CTRC_TRIM_OUT_SEL_BIT];

    // Unused positions are masked on write so they always read back zero.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cal_ctrl <= `CTRC_CAL_RESET;
        end else if (cal_write) begin
            cal_ctrl <= keep_bits(reg_wdata, `CTRC_CAL_MASK);
        end
    end

    // The trim source bits act as levels, so the load keeps running for as
    // long as bit 0 stays set.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trim_src_ctrl <= `CTRC_TRIM_SRC_RESET;
        end else if (trim_src_write) begin
            trim_src_ctrl <= keep_bits(reg_wdata, `CTRC_TRIM_SRC_MASK);
        end
    end

    // ****************************************
    // Shadow trim registers
    // ****************************************

    // While the load bit is set the shadows track the fuses every cycle, so a
    // host write to a shadow is lost until the load bit is cleared again.
    genvar g;
    generate
        for (g = 0; g < SHADOW_COUNT; g = g + 1) begin : gen_shadow
            always @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    shadow[g] <= `CTRC_SHADOW_RESET;
                end else if (trim_load) begin
                    shadow[g] <= fused_trim[g*DW +: DW];
                end else if (reg_write && shadow_index(reg_addr) == g) begin
                    shadow[g] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ****************************************
    // Register read port
    // ****************************************

    reg [DW-1:0] next_rdata;
    integer rd_index;

    // Unmapped addresses fall through to the zero default.
    always @* begin
        next_rdata = {DW{1'b0}};
        rd_index = shadow_index(reg_addr);
        case (reg_addr)
            `CTRC_ADDR_CAL: begin
                next_rdata = cal_ctrl;
            end
            `CTRC_ADDR_TRIM_SRC: begin
                next_rdata = trim_src_ctrl;
            end
            default: begin
                if (rd_index < SHADOW_COUNT) begin
                    next_rdata = shadow[rd_index];
                end else begin
                    next_rdata = {DW{1'b0}};
                end
            end
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= {DW{1'b0}};
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ****************************************
    // Effective trim word
    // ****************************************

    reg [SHADOW_COUNT*DW-1:0] next_trim;
    integer t;

    always @* begin
        next_trim = fused_trim;
        for (t = 0; t < SHADOW_COUNT; t = t + 1) begin
            if (trim_out_sel) begin
                next_trim[t*DW +: DW] = shadow[t];
            end
        end
    end

    // ****************************************
    // Decoded control bits
    // ****************************************

    wire cal_short;
    wire cal_ground;
    wire cal_pos_cont;
    wire cal_neg_cont;
    wire [DW-1:0] monitor_sel;

    assign cal_short = cal_ctrl[`CTRC_CAL_SHORT_BIT];
    assign cal_ground = cal_ctrl[`CTRC_CAL_GROUND_BIT];
    assign cal_pos_cont = cal_ctrl[`CTRC_CAL_POS_CONT_BIT];
    assign cal_neg_cont = cal_ctrl[`CTRC_CAL_NEG_CONT_BIT];
    assign monitor_sel = shadow[`CTRC_MONITOR_INDEX];

    // ****************************************
    // Input switch outputs
    // ****************************************

    // Every output is a flop fed from the stored state, so each follows its
    // register bit with one clock of delay and never glitches on decode.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            channel_select_override <= 1'b0;
            amp_input_short <= 1'b0;
            amp_inv_to_ground <= 1'b0;
            pos_continuity_check <= 1'b0;
            neg_continuity_check <= 1'b0;
            noninv_to_ref_div <= 1'b0;
        end else begin
            channel_select_override <= cal_short | cal_ground;
            amp_input_short <= cal_short;
            amp_inv_to_ground <= cal_ground;
            pos_continuity_check <= cal_pos_cont;
            neg_continuity_check <= cal_neg_cont;
            noninv_to_ref_div <= cal_neg_cont;
        end
    end

    // ****************************************
    // Trim word output
    // ****************************************

    // The whole word moves in one edge, so the trimmed circuits never see a
    // mix of fused and shadow bytes while the source select changes.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trim_out <= {SHADOW_COUNT*DW{1'b0}};
        end else begin
            trim_out <= next_trim;
        end
    end

    // ****************************************
    // Trim field outputs
    // ****************************************

    // The offset and reference fields follow the effective word, so they
    // switch source together with the rest of the trim outputs.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reference_adjust <= {`CTRC_REF_ADJ_W{1'b0}};
            offset_adjust <= {`CTRC_OFFSET_W{1'b0}};
            offset_cal_active <= 1'b0;
        end else begin
            reference_adjust <= next_trim[`CTRC_REF_ADJ_INDEX*DW +: `CTRC_REF_ADJ_W];
            offset_adjust <= next_trim[`CTRC_OFFSET_INDEX*DW +: `CTRC_OFFSET_W];
            offset_cal_active <= trim_out_sel;
        end
    end

    // ****************************************
    // Supply monitor outputs
    // ****************************************

    // Several monitors may be selected at once; the converter path has to
    // sort out any conflict, since no priority is applied here.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            monitor_pos_rail <= 1'b0;
            monitor_neg_rail <= 1'b0;
            monitor_five_volt <= 1'b0;
            monitor_reference <= 1'b0;
        end else begin
            monitor_pos_rail <= monitor_sel[`CTRC_MON_POS_BIT];
            monitor_neg_rail <= monitor_sel[`CTRC_MON_NEG_BIT];
            monitor_five_volt <= monitor_sel[`CTRC_MON_FIVE_BIT];
            monitor_reference <= monitor_sel[`CTRC_MON_REF_BIT];
        end
    end

endmodule

`default_nettype wire

// ### testbench/ctrc_checker_assertions.sv
// Concurrent checks on the ports of the calibration and trim control registers.
`default_nettype none
module ctrc_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [39:0] fused_trim,
    input wire logic [39:0] trim_out,
    input wire logic channel_select_override,
    input wire logic amp_input_short,
    input wire logic amp_inv_to_ground,
    input wire logic pos_continuity_check,
    input wire logic neg_continuity_check,
    input wire logic noninv_to_ref_div,
    input wire logic offset_cal_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wc;
    logic ws;
    assign wc = reg_write && reg_addr == 5'h10;
    assign ws = reg_write && reg_addr == 5'h11;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // A second write right behind the first would not reach the output before the check; it is excluded anyway.
    AST_SHORT: assert property (wc ##1 !wc |=> amp_input_short == $past(reg_wdata[7], 2))
        else $error("short switch wrong");
    AST_POS: assert property (wc ##1 !wc |=> pos_continuity_check == $past(reg_wdata[4], 2))
        else $error("positive check wrong");
    AST_OVR: assert property (channel_select_override == (amp_input_short || amp_inv_to_ground))
        else $error("override wrong");
    AST_NEGREF: assert property (neg_continuity_check == noninv_to_ref_div)
        else $error("negative check wrong");
    AST_RVALID: assert property (reg_rvalid == $past(reg_read))
        else $error("read valid wrong");
    AST_CALZ: assert property (reg_read && reg_addr == 5'h10 |=> (reg_rdata & 8'h65) == 8'h00)
        else $error("unused bit read set");
    AST_OCA: assert property (ws ##1 !ws |=> offset_cal_active == $past(reg_wdata[1], 2))
        else $error("trim select wrong");
    AST_TRIM: assert property (!offset_cal_active [*3] |-> trim_out == fused_trim)
        else $error("trim not fused");
    cover property (wc && reg_wdata[7]);
    cover property (ws && reg_wdata[0]);
    cover property ($rose(offset_cal_active));
endmodule
`default_nettype wire

// ### testbench/ctrc_host.sv
// Host side model that issues single-byte register reads and writes.
`default_nettype none
module ctrc_host (
    input wire logic clock,
    output logic [4:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_write, reg_read} = 15'h0;
    // Released address and data are inverted so a stale value never passes for a held one.
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clock);
        #1 {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge clock);
        #1 {reg_write, reg_read, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the calibration and trim control registers.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [39:0] FUSED = 40'h0a_5c_c3_2e_17;
    logic clock, resetn, reg_write, reg_read, reg_rvalid, offset_cal_active;
    logic channel_select_override, amp_input_short, amp_inv_to_ground, pos_continuity_check;
    logic neg_continuity_check, noninv_to_ref_div;
    logic monitor_pos_rail, monitor_neg_rail, monitor_five_volt, monitor_reference;
    logic [4:0] reg_addr, reference_adjust;
    logic [3:0] offset_adjust;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [39:0] fused_trim, trim_out;
    int n_errors = 0;
    int n_checks = 0;
    ctrc_regs i_ctrc_regs (.*);
    ctrc_host i_ctrc_host (.*);
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One idle edge after each write lets the control outputs catch up with the store.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_ctrc_host.acc(1'b1, a, d, q);
        @(posedge clock);
        #1;
    endtask
    task automatic rd(input string what, input logic [4:0] a, input logic [7:0] exp);
        i_ctrc_host.acc(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd("cal reset", 5'h10, 8'h00);
        rd("src reset", 5'h11, 8'h00);
        chk("trim fused", FUSED, trim_out);
    endtask
    task automatic t_cal;
        logic [7:0] v [5] = '{8'h80, 8'h02, 8'h10, 8'h08, 8'hff};
        foreach (v[i]) begin
            wr(5'h10, v[i]);
            chk("switches", {v[i][7] | v[i][1], v[i][7], v[i][1], v[i][4], v[i][3], v[i][3]},
                {channel_select_override, amp_input_short, amp_inv_to_ground,
                pos_continuity_check, neg_continuity_check, noninv_to_ref_div});
            rd("cal readback", 5'h10, v[i] & 8'h9a);
        end
    endtask
    task automatic t_trim;
        wr(5'h11, 8'h01);
        rd("shadow load", 5'h13, FUSED[15:8]);
        wr(5'h11, 8'hff);
        rd("src readback", 5'h11, 8'h03);
        wr(5'h11, 8'h02);
        chk("monitors", 4'ha, {monitor_reference, monitor_five_volt, monitor_neg_rail, monitor_pos_rail});
        wr(5'h13, 8'h05);
        wr(5'h12, 8'h1f);
        wr(5'h16, 8'h05);
        chk("trim shadow", {8'h05, FUSED[31:16], 8'h05, 8'h1f}, trim_out);
        chk("offset", 4'h5, offset_adjust);
        chk("reference", 5'h1f, reference_adjust);
        chk("monitors", 4'h5, {monitor_reference, monitor_five_volt, monitor_neg_rail, monitor_pos_rail});
        rd("unmapped", 5'h1f, 8'h00);
        wr(5'h11, 8'h00);
        chk("trim fused", FUSED, trim_out);
    endtask
    task automatic stop_test;
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    initial begin
        resetn = 0;
        fused_trim = FUSED;
        repeat (6) @(posedge clock);
        #1 resetn = 1;
        t_reset();
        t_cal();
        t_trim();
        stop_test();
    end
    // The tests need about sixty cycles; about thirty times that marks a hang.
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
bind ctrc_regs ctrc_checker i_ctrc_checker (.*);
`default_nettype wire
